// *** design/cpx_pkg.sv ***
// shared constants and types for the add/shift/branch execution unit
package cpx_pkg;
  // opcode bytes; odd ones of the add/and groups are byte forms
  localparam logic [7:0] OP_ADD_RR = 8'h30;
  localparam logic [7:0] OP_ADD_RM = 8'h32;
  localparam logic [7:0] OP_ADD_IR = 8'h34;
  localparam logic [7:0] OP_ADD_MR = 8'h36;
  localparam logic [7:0] OP_AND_RR = 8'h40;
  localparam logic [7:0] OP_AND_RM = 8'h42;
  localparam logic [7:0] OP_AND_IR = 8'h44;
  localparam logic [7:0] OP_AND_IM = 8'h46;
  localparam logic [7:0] OP_ADQ_R = 8'h82;
  localparam logic [7:0] OP_ADQ_M = 8'h84;
  localparam logic [7:0] OP_ASR_I = 8'hb4;
  localparam logic [7:0] OP_ASRL_I = 8'hb5;
  localparam logic [7:0] OP_ASR_R = 8'hb6;
  localparam logic [7:0] OP_ASRL_R = 8'hb7;
  localparam logic [3:0] OP_BR_HI = 4'hc;
  localparam logic [6:0] SIZE_MASK = 7'h7f;
  // instruction word fields
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 8;
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 4;
  localparam int DST_MSB = 3;
  localparam int DST_LSB = 0;
  localparam logic [3:0] HIGH_WORD_IDX = 4'hf;
  localparam logic [16:0] BR_PC_BIAS = 17'h00004;
  localparam logic [16:0] NEXT_BIAS = 17'h00002;
  localparam logic [7:0] UPPER_ZERO = 8'h00;
  // apb map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_REG0 = 8'h40;
  localparam logic [7:0] ADDR_REGN = 8'h7c;
  localparam logic CTRL_RESET = 1'b1;
  typedef struct packed {
    logic v;
    logic c;
    logic n;
    logic z;
  } cpx_flags_type;
  typedef struct packed {
    logic [15:0] value;
    cpx_flags_type fl;
  } cpx_alu_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IMM,
    ST_RD,
    ST_WR
  } cpx_state_type;
  typedef struct packed {
    logic req;
    logic wr;
    logic byte_sz;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpx_mem_type;
endpackage : cpx_pkg

// *** design/cpx_exec_unit.sv ***
// execution unit for quick add, add, and, arithmetic shift and branch
module cpx_exec_unit
  import cpx_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // instruction issue from the fetch pipeline
  input wire logic ISSUE_VALID_I,
  input wire logic [15:0] ISSUE_WORD_I,
  input wire logic [15:0] ISSUE_EXT1_I,
  input wire logic [15:0] ISSUE_EXT2_I,
  input wire logic [16:0] ISSUE_OPA_I,
  output logic ISSUE_READY_O,
  output logic DONE_O,
  output logic PC_LOAD_O,
  output logic [15:0] PC_VALUE_O,
  output logic BRANCH_TAKEN_O,
  // memory bus
  output logic MEM_REQ_O,
  output logic MEM_WR_O,
  output logic MEM_BYTE_O,
  output logic [15:0] MEM_ADDR_O,
  output logic [15:0] MEM_WDATA_O,
  input wire logic MEM_ACK_I,
  input wire logic [15:0] MEM_RDATA_I
);

  typedef struct packed {
    cpx_state_type st;
    logic [15:0][15:0] regs;
    cpx_flags_type fl;
    logic en;
    logic [7:0] op;
    logic [3:0] rd;
    logic [15:0] src;
    cpx_mem_type mem;
    logic ready;
    logic done;
    logic pc_load;
    logic [15:0] pc_val;
    logic taken;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cpx_core_type;

  cpx_core_type s_r;
  cpx_core_type s_nxt;
  logic rst_meta_r;
  logic rst_sync_n_r;

  ////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // arithmetic helpers
  function automatic cpx_alu_type add_f(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic bsz);
    cpx_alu_type r;
    logic [16:0] w;
    logic [8:0] y;
    w = {1'b0, a} + {1'b0, b};
    y = {1'b0, a[7:0]} + {1'b0, b[7:0]};
    if (bsz) begin
      r.value = {7'h00, y};
      r.fl.c = y[8];
      r.fl.v = (a[7] == b[7]) && (y[7] != a[7]);
      r.fl.n = y[7];
      r.fl.z = (y[7:0] == 8'h00);
    end else begin
      r.value = w[15:0];
      r.fl.c = w[16];
      r.fl.v = (a[15] == b[15]) && (w[15] != a[15]);
      r.fl.n = w[15];
      r.fl.z = (w[15:0] == 16'h0000);
    end
    return r;
  endfunction : add_f

  function automatic cpx_alu_type and_f(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic bsz,
                                        input logic cin);
    cpx_alu_type r;
    r.value = bsz ? {UPPER_ZERO, a[7:0] & b[7:0]} : (a & b);
    r.fl.c = cin;
    r.fl.v = 1'b0;
    r.fl.n = bsz ? r.value[7] : r.value[15];
    r.fl.z = bsz ? (r.value[7:0] == 8'h00) : (r.value == 16'h0000);
    return r;
  endfunction : and_f

  // add or and, chosen by opcode group
  function automatic cpx_alu_type alu_f(input logic [7:0] op,
                                        input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic cin);
    logic bsz;
    bsz = op[0];
    if (op[6]) begin
      return and_f(a, b, bsz, cin);
    end
    return add_f(a, b, bsz);
  endfunction : alu_f

  // branch condition for the low opcode nibble
  function automatic logic cond_f(input logic [3:0] c, input cpx_flags_type f);
    logic nv;
    nv = f.n ^ f.v;
    unique case (c)
      4'h0: return 1'b1;
      4'h1: return !f.c;
      4'h2: return f.c;
      4'h3: return f.z;
      4'h4: return !f.z;
      4'h5: return !(f.c | f.z);
      4'h6: return f.c | f.z;
      4'h7: return !(f.z | nv);
      4'h8: return f.z | nv;
      4'h9: return !nv;
      4'ha: return nv;
      4'hb: return f.v;
      4'hc: return !f.v;
      4'hd: return !(f.n | f.z);
      4'he: return !f.n;
      4'hf: return f.n;
    endcase
  endfunction : cond_f

  ////////////////////////////////////////////////////////////////////
  // next state
  logic [7:0] i_op;
  logic [3:0] i_rs;
  logic [3:0] i_rd;
  logic [15:0] r_s;
  logic [15:0] r_d;
  logic [15:0] r_hi;
  logic [3:0] sh_n;
  logic [31:0] sh_in;
  logic [31:0] sh_out;
  logic sh_long;
  logic [16:0] pc_base;
  logic [16:0] pc_next;
  logic [15:0] br_disp;
  logic [15:0] rd_opnd;
  logic apb_wr;
  logic [3:0] apb_idx;
  cpx_alu_type res;

  always_comb begin
    s_nxt = s_r;
    i_op = ISSUE_WORD_I[OPC_MSB:OPC_LSB];
    i_rs = ISSUE_WORD_I[SRC_MSB:SRC_LSB];
    i_rd = ISSUE_WORD_I[DST_MSB:DST_LSB];
    r_s = s_r.regs[i_rs];
    r_d = s_r.regs[i_rd];
    r_hi = s_r.regs[HIGH_WORD_IDX];
    sh_long = i_op[0];
    sh_n = i_op[1] ? r_s[3:0] : i_rs;
    sh_in = sh_long ? {r_hi, r_d} : {{16{r_d[15]}}, r_d};
    sh_out = 32'($signed(sh_in) >>> sh_n);
    pc_base = ISSUE_OPA_I + BR_PC_BIAS;
    pc_next = ISSUE_OPA_I + NEXT_BIAS;
    br_disp = {{8{ISSUE_WORD_I[7]}}, ISSUE_WORD_I[7:0]};
    rd_opnd = s_r.mem.byte_sz ? {UPPER_ZERO, MEM_RDATA_I[7:0]} : MEM_RDATA_I;
    res = alu_f(s_r.op, s_r.src, s_r.regs[s_r.rd], s_r.fl.c);
    s_nxt.done = 1'b0;
    s_nxt.pc_load = 1'b0;

    // apb register access
    apb_idx = PADDR_I[5:2];
    apb_wr = PSEL_I && PENABLE_I && PWRITE_I && s_r.pready;
    s_nxt.pready = PSEL_I && !PENABLE_I;
    s_nxt.prdata = 32'h0000_0000;
    s_nxt.pslverr = 1'b0;
    if (PSEL_I && !PENABLE_I) begin
      if (PADDR_I == ADDR_CTRL) begin
        s_nxt.prdata = {31'h0000_0000, s_r.en};
      end else if (PADDR_I == ADDR_FLAGS) begin
        s_nxt.prdata = {28'h000_0000, s_r.fl};
      end else if (PADDR_I == ADDR_STATE) begin
        s_nxt.prdata = {28'h000_0000, s_r.taken, s_r.st, !s_r.ready};
      end else if (PADDR_I >= ADDR_REG0 && PADDR_I <= ADDR_REGN
                   && PADDR_I[1:0] == 2'b00) begin
        s_nxt.prdata = {16'h0000, s_r.regs[apb_idx]};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (apb_wr) begin
      if (PADDR_I == ADDR_CTRL) begin
        s_nxt.en = PWDATA_I[0];
      end else if (PADDR_I == ADDR_FLAGS) begin
        s_nxt.fl = PWDATA_I[3:0];
      end else if (PADDR_I >= ADDR_REG0 && PADDR_I <= ADDR_REGN
                   && PADDR_I[1:0] == 2'b00) begin
        s_nxt.regs[apb_idx] = PWDATA_I[15:0];
      end
    end

    // execution; its writes land after software's and so win
    unique case (s_r.st)
      ST_IDLE: begin
        if (ISSUE_VALID_I && s_r.ready) begin
          s_nxt.op = i_op;
          s_nxt.rd = i_rd;
          s_nxt.done = 1'b1;
          s_nxt.mem.byte_sz = i_op[0];
          unique case (i_op & {1'b1, SIZE_MASK} & 8'hfe)
            OP_ADD_RR, OP_AND_RR: begin
              res = alu_f(i_op, r_s, r_d, s_r.fl.c);
              s_nxt.regs[i_rd] = res.value;
              s_nxt.fl = res.fl;
            end
            OP_ADQ_R: begin
              res = add_f({12'h000, i_rs}, r_d, i_op[0]);
              s_nxt.regs[i_rd] = res.value;
              s_nxt.fl = res.fl;
            end
            OP_ADD_IR, OP_AND_IR: begin
              s_nxt.src = ISSUE_EXT1_I;
              s_nxt.done = 1'b0;
              s_nxt.st = ST_IMM;
            end
            OP_ADD_RM, OP_AND_RM, OP_AND_IM, OP_ADQ_M: begin
              if (i_op[7]) begin
                s_nxt.src = {12'h000, i_rs};
              end else if (i_op[2]) begin
                s_nxt.src = ISSUE_EXT2_I;
              end else begin
                s_nxt.src = r_s;
              end
              s_nxt.mem.addr = ISSUE_EXT1_I + r_d;
              s_nxt.mem.req = 1'b1;
              s_nxt.mem.wr = 1'b0;
              s_nxt.done = 1'b0;
              s_nxt.st = ST_RD;
            end
            OP_ADD_MR: begin
              s_nxt.mem.addr = ISSUE_EXT1_I + r_s;
              s_nxt.mem.req = 1'b1;
              s_nxt.mem.wr = 1'b0;
              s_nxt.done = 1'b0;
              s_nxt.st = ST_RD;
            end
            OP_ASR_I, OP_ASR_R: begin
              s_nxt.mem.byte_sz = 1'b0;
              s_nxt.regs[i_rd] = sh_out[15:0];
              if (sh_long) begin
                // same register as both halves: high half wins
                s_nxt.regs[HIGH_WORD_IDX] = sh_out[31:16];
              end
              if (sh_n == 4'h0) begin
                s_nxt.fl.c = i_op[1] ? 1'b0 : s_r.fl.c;
              end else begin
                s_nxt.fl.c = sh_in[sh_n - 4'h1];
              end
              s_nxt.fl.v = 1'b0;
              s_nxt.fl.n = sh_long ? sh_out[31] : sh_out[15];
              s_nxt.fl.z = sh_long ? (sh_out == 32'h0000_0000)
                                   : (sh_out[15:0] == 16'h0000);
            end
            default: begin
              if (i_op[7:4] == OP_BR_HI) begin
                // flags untouched on either path
                s_nxt.taken = cond_f(i_op[3:0], s_r.fl);
                s_nxt.pc_load = 1'b1;
                if (s_nxt.taken) begin
                  s_nxt.pc_val = pc_base[16:1] + br_disp;
                end else begin
                  s_nxt.pc_val = pc_next[16:1];
                end
              end
            end
          endcase
        end
      end
      ST_IMM: begin
        s_nxt.regs[s_r.rd] = res.value;
        s_nxt.fl = res.fl;
        s_nxt.done = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      ST_RD: begin
        if (MEM_ACK_I) begin
          s_nxt.mem.req = 1'b0;
          if (s_r.op[7:1] == OP_ADD_MR[7:1]) begin
            res = add_f(rd_opnd, s_r.regs[s_r.rd], s_r.op[0]);
            s_nxt.regs[s_r.rd] = res.value;
            s_nxt.fl = res.fl;
            s_nxt.done = 1'b1;
            s_nxt.st = ST_IDLE;
          end else begin
            res = alu_f(s_r.op, s_r.src, rd_opnd, s_r.fl.c);
            s_nxt.fl = res.fl;
            s_nxt.mem.wdata = s_r.mem.byte_sz ? {UPPER_ZERO, res.value[7:0]}
                                              : res.value;
            s_nxt.mem.req = 1'b1;
            s_nxt.mem.wr = 1'b1;
            s_nxt.st = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (MEM_ACK_I) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.mem.wr = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
    // a one-cycle gap after every accepted issue keeps done unambiguous
    s_nxt.ready = s_nxt.en && (s_nxt.st == ST_IDLE)
                  && !(ISSUE_VALID_I && s_r.ready);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge MCLK_I or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.en <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O = s_r.prdata;
  assign PREADY_O = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign ISSUE_READY_O = s_r.ready;
  assign DONE_O = s_r.done;
  assign PC_LOAD_O = s_r.pc_load;
  assign PC_VALUE_O = s_r.pc_val;
  assign BRANCH_TAKEN_O = s_r.taken;
  assign MEM_REQ_O = s_r.mem.req;
  assign MEM_WR_O = s_r.mem.wr;
  assign MEM_BYTE_O = s_r.mem.byte_sz;
  assign MEM_ADDR_O = s_r.mem.addr;
  assign MEM_WDATA_O = s_r.mem.wdata;

endmodule : cpx_exec_unit

// *** sim/cpx_mem_model.sv ***
// memory responder on the unit's data bus, with wait states
module cpx_mem_model (
  // clock
  input wire logic clk_i,
  // bus from the unit, and the wait-state count
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic byte_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wait_i,
  // answer
  output logic ack_o,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [1:0] cnt = 2'h0;
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0;
  end
  always @(posedge clk_i) begin
    if (req_i && !ack_o && cnt == wait_i) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i[8:1]];
      cnt <= 2'h0;
      if (wr_i) begin
        mem[addr_i[8:1]] <= byte_i ? {mem[addr_i[8:1]][15:8], wdata_i[7:0]} : wdata_i;
      end
    end else begin
      ack_o <= 1'b0;
      // data inverted every cycle once the answer is gone
      rdata_o <= ~rdata_o;
      cnt <= (req_i && !ack_o) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule : cpx_mem_model

// *** sim/cpx_exec_unit_assertions.sv ***
// port checks for the execution unit
module cpx_exec_checker
  import cpx_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  // issue
  input wire logic ISSUE_VALID_I,
  input wire logic [15:0] ISSUE_WORD_I,
  input wire logic [16:0] ISSUE_OPA_I,
  input wire logic ISSUE_READY_O,
  input wire logic DONE_O,
  input wire logic PC_LOAD_O,
  input wire logic [15:0] PC_VALUE_O,
  input wire logic BRANCH_TAKEN_O,
  // memory
  input wire logic MEM_REQ_O,
  input wire logic MEM_WR_O,
  input wire logic MEM_BYTE_O,
  input wire logic [15:0] MEM_ADDR_O,
  input wire logic [15:0] MEM_WDATA_O,
  input wire logic MEM_ACK_I
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic take;
  logic [7:0] opc;
  logic [7:0] disp;
  assign take = ISSUE_VALID_I && ISSUE_READY_O;
  assign opc = ISSUE_WORD_I[OPC_MSB:OPC_LSB];
  assign disp = ISSUE_WORD_I[7:0];
  //////////////////////////////////////////////////////////////////////
  sequence s_rd_acked;
    MEM_REQ_O && !MEM_WR_O && MEM_ACK_I;
  endsequence
  sequence s_wr_start;
    MEM_REQ_O && MEM_WR_O && $stable(MEM_ADDR_O);
  endsequence
  property p_apb_answer;
    PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late or long");
  property p_quick_once;
    take && opc == OP_ADQ_R |=> DONE_O ##1 !DONE_O;
  endproperty
  a_quick_once: assert property (p_quick_once)
    else $error("quick add not one cycle");
  property p_imm_twice;
    take && opc == OP_ADD_IR |=> !DONE_O ##1 DONE_O;
  endproperty
  a_imm_twice: assert property (p_imm_twice)
    else $error("immediate add not two cycles");
  property p_issue_gap;
    take |=> !ISSUE_READY_O;
  endproperty
  a_issue_gap: assert property (p_issue_gap)
    else $error("issue ready not dropped");
  property p_branch_pc;
    take && opc[7:4] == OP_BR_HI |=> PC_LOAD_O && DONE_O && PC_VALUE_O == (BRANCH_TAKEN_O ?
      16'(($past(ISSUE_OPA_I) + BR_PC_BIAS) >> 1) + 16'(signed'($past(disp))) :
      16'(($past(ISSUE_OPA_I) + NEXT_BIAS) >> 1));
  endproperty
  a_branch_pc: assert property (p_branch_pc)
    else $error("branch target wrong");
  property p_always;
    take && opc == {OP_BR_HI, 4'h0} |=> BRANCH_TAKEN_O;
  endproperty
  a_always: assert property (p_always)
    else $error("unconditional branch not taken");
  property p_mem_hold;
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WR_O);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped early");
  property p_rmw;
    take && (opc == OP_ADD_RM || opc == OP_ADQ_M) |=> ##[0:4] s_rd_acked ##1 s_wr_start;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("no write back to read address");
  property p_byte_upper;
    MEM_REQ_O && MEM_WR_O && MEM_BYTE_O |-> MEM_WDATA_O[15:8] == UPPER_ZERO;
  endproperty
  a_byte_upper: assert property (p_byte_upper)
    else $error("byte write upper not zero");
  property p_write_done;
    MEM_REQ_O && MEM_WR_O && MEM_ACK_I |=> DONE_O && !MEM_REQ_O;
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("no done after write");
endmodule : cpx_exec_checker
bind cpx_exec_unit cpx_exec_checker cpx_exec_checker_inst (.MCLK_I, .RST_N_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .ISSUE_VALID_I, .ISSUE_WORD_I, .ISSUE_OPA_I, .ISSUE_READY_O,
  .DONE_O, .PC_LOAD_O, .PC_VALUE_O, .BRANCH_TAKEN_O, .MEM_REQ_O, .MEM_WR_O, .MEM_BYTE_O,
  .MEM_ADDR_O, .MEM_WDATA_O, .MEM_ACK_I);

// *** sim/tb.sv ***
// self-checking bench for the add, shift and branch execution unit
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb
  import cpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic ivalid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, iready, done, pcload, taken, mreq, mwr, mbyte, mack;
  logic [15:0] iword = 16'h0;
  logic [15:0] ext1 = 16'h0;
  logic [15:0] ext2 = 16'h0;
  logic [16:0] opcode_byte_address = 17'h0;
  logic [15:0] pcval, maddr, mwdata, mrdata;
  logic [1:0] mwait = 2'h1;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  cpx_exec_unit cpx_exec_unit_inst (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .ISSUE_VALID_I(ivalid), .ISSUE_WORD_I(iword),
    .ISSUE_EXT1_I(ext1), .ISSUE_EXT2_I(ext2), .ISSUE_OPA_I(opcode_byte_address), .ISSUE_READY_O(iready),
    .DONE_O(done), .PC_LOAD_O(pcload), .PC_VALUE_O(pcval), .BRANCH_TAKEN_O(taken),
    .MEM_REQ_O(mreq), .MEM_WR_O(mwr), .MEM_BYTE_O(mbyte), .MEM_ADDR_O(maddr),
    .MEM_WDATA_O(mwdata), .MEM_ACK_I(mack), .MEM_RDATA_I(mrdata));
  cpx_mem_model cpx_mem_model_inst (.clk_i(clk), .req_i(mreq), .wr_i(mwr), .byte_i(mbyte),
    .addr_i(maddr), .wdata_i(mwdata), .wait_i(mwait), .ack_o(mack), .rdata_o(mrdata));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // outputs read right after an edge still hold the value sampled there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    `CHK("pready", 1'b1, pready)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0, d}, q, e);
  endtask : put
  function automatic logic [7:0] ra(input logic [3:0] i);
    return ADDR_REG0 + {2'b00, i, 2'b00};
  endfunction : ra
  task automatic issue(input logic [15:0] w, input logic [15:0] e1, input logic [16:0] a);
    int n;
    n = 0;
    ivalid <= 1'b1;
    iword <= w;
    ext1 <= e1;
    opcode_byte_address <= a;
    do begin @(posedge clk); n++; end while (iready !== 1'b1 && n < 50);
    ivalid <= 1'b0;
    do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 100);
    `CHK("done", 1'b1, done)
  endtask : issue
  task automatic expect_rf(input logic [3:0] i, input logic [15:0] d, input logic [3:0] f);
    logic [31:0] q;
    logic e;
    apb(1'b0, ra(i), 32'h0, q, e);
    `CHK("register", {16'h0, d}, q)
    apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
    `CHK("flags", f, q[3:0])
  endtask : expect_rf
  function automatic logic br_cond(input logic [3:0] c, input logic [3:0] f);
    logic v, cy, n, z;
    {v, cy, n, z} = f;
    case (c)
      4'h0: return 1'b1;
      4'h1: return !cy;
      4'h2: return cy;
      4'h3: return z;
      4'h4: return !z;
      4'h5: return !(cy | z);
      4'h6: return cy | z;
      4'h7: return !(z | (n ^ v));
      4'h8: return z | (n ^ v);
      4'h9: return !(n ^ v);
      4'ha: return n ^ v;
      4'hb: return v;
      4'hc: return !v;
      4'hd: return !(n | z);
      4'he: return !n;
      default: return n;
    endcase
  endfunction : br_cond
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    `CHK("ctrl", 32'h1, q)
    // disabled unit must refuse issue and report busy
    apb(1'b1, ADDR_CTRL, 32'h0, q, e);
    apb(1'b0, ADDR_STATE, 32'h0, q, e);
    `CHK("state off", 32'h1, q)
    apb(1'b1, ADDR_CTRL, 32'h1, q, e);
    apb(1'b1, ADDR_STATE, 32'hf, q, e);
    apb(1'b0, ADDR_STATE, 32'h0, q, e);
    `CHK("state", 32'h0, q)
    apb(1'b1, 8'h20, 32'h5, q, e);
    `CHK("unmapped", 1'b1, e)
  endtask : t_regs
  task automatic t_add();
    put(ra(1), 16'hfffe);
    issue(16'h8231, 16'h0, 17'h0);
    expect_rf(1, 16'h0001, 4'b0100);
    put(ra(2), 16'h00ff);
    issue(16'h8312, 16'h0, 17'h0);
    expect_rf(2, 16'h0100, 4'b0101);
    put(ra(4), 16'h7fff);
    issue(16'h3404, 16'h0001, 17'h0);
    expect_rf(4, 16'h8000, 4'b1010);
    put(ra(6), 16'h0080);
    issue(16'h3506, 16'h0080, 17'h0);
    expect_rf(6, 16'h0100, 4'b1101);
  endtask : t_add
  task automatic t_and();
    put(ADDR_FLAGS, 16'h000c);
    put(ra(5), 16'h12f0);
    put(ra(6), 16'hff3c);
    issue(16'h4156, 16'h0, 17'h0);
    expect_rf(6, 16'h0030, 4'b0100);
    put(ra(7), 16'h8f00);
    issue(16'h4407, 16'h8100, 17'h0);
    expect_rf(7, 16'h8100, 4'b0110);
  endtask : t_and
  task automatic t_asr();
    put(ADDR_FLAGS, 16'h0008);
    put(ra(7), 16'h8010);
    put(ra(8), 16'hfff5);
    issue(16'hb687, 16'h0, 17'h0);
    expect_rf(7, 16'hfc00, 4'b0110);
    put(ra(8), 16'hfff0);
    issue(16'hb687, 16'h0, 17'h0);
    expect_rf(7, 16'hfc00, 4'b0010);
    // lower half kept off the high-word register
    put(ra(15), 16'h8002);
    put(ra(9), 16'h0001);
    issue(16'hb519, 16'h0, 17'h0);
    expect_rf(9, 16'h0000, 4'b0110);
    expect_rf(15, 16'hc001, 4'b0110);
    issue(16'hb789, 16'h0, 17'h0);
    expect_rf(15, 16'hc001, 4'b0010);
    issue(16'hb4f7, 16'h0, 17'h0);
    expect_rf(7, 16'hffff, 4'b0110);
  endtask : t_asr
  task automatic t_mem();
    cpx_mem_model_inst.mem[8'h90] = 16'h1234;
    put(ra(3), 16'h0100);
    put(ra(2), 16'h0001);
    issue(16'h3223, 16'h0020, 17'h0);
    `CHK("mem word", 16'h1235, cpx_mem_model_inst.mem[8'h90])
    put(ra(2), 16'h00ff);
    issue(16'h3323, 16'h0020, 17'h0);
    `CHK("mem byte", 16'h1234, cpx_mem_model_inst.mem[8'h90])
    expect_rf(2, 16'h00ff, 4'b0100);
    issue(16'h3632, 16'h0020, 17'h0);
    expect_rf(2, 16'h1333, 4'b0000);
    issue(16'h84f3, 16'h0020, 17'h0);
    `CHK("mem quick", 16'h1243, cpx_mem_model_inst.mem[8'h90])
    mwait <= 2'h0;
    ext2 <= 16'h0ff0;
    issue(16'h4603, 16'h0020, 17'h0);
    `CHK("mem and", 16'h0240, cpx_mem_model_inst.mem[8'h90])
    put(ADDR_FLAGS, 16'h0004);
    mwait <= 2'h3;
    issue(16'h4323, 16'h0020, 17'h0);
    `CHK("mem and byte", 16'h0200, cpx_mem_model_inst.mem[8'h90])
    expect_rf(2, 16'h1333, 4'b0101);
  endtask : t_mem
  task automatic t_branch();
    logic [3:0] pats [3] = '{4'b0000, 4'b1111, 4'b0010};
    logic [31:0] q;
    logic [7:0] d;
    logic e;
    logic [15:0] pc_exp;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 16; c++) begin
        d = c[0] ? 8'h7f : 8'h80;
        put(ADDR_FLAGS, {12'h0, pats[p]});
        issue({OP_BR_HI, c[3:0], d}, 16'h0, 17'h00100);
        `CHK("taken", br_cond(c[3:0], pats[p]), taken)
        pc_exp = br_cond(c[3:0], pats[p]) ? 16'h0082 + {{8{d[7]}}, d} : 16'h0081;
        `CHK("pc", pc_exp, pcval)
        apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
        `CHK("branch flags", pats[p], q[3:0])
      end
    end
  endtask : t_branch
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_regs();
    t_add();
    t_and();
    t_asr();
    t_mem();
    t_branch();
    end_of_test();
  end
endmodule : tb
